// ### core/adc_test_pattern_generator.sv
// Converter test pattern generator with its configuration registers.
`timescale 1ns/100ps
module adc_test_pattern_generator (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [tpg_pkg::AW-1:0] reg_addr,
	input  wire logic [7:0]             reg_wdata,
	output logic [7:0]                  reg_rdata,
	output logic                        reg_rvalid,
	input  wire logic [tpg_pkg::DW-1:0] adc_data,
	output logic                        out_valid,
	input  wire logic                   out_ready,
	output logic [tpg_pkg::DW-1:0]      out_data,
	output logic                        out_fmt_bypass,
	output logic                        test_active,
	output logic                        transport_test_en,
	output logic [3:0]                  link_pattern_sel,
	output logic [1:0]                  link_inject_sel,
	output logic                        link_exit_pending
);
	import tpg_pkg::*;

	soft_state_type sr_state_q;
	logic [7:0]     test_mode_q;
	logic [7:0]     transport_q;
	logic [7:0]     link_test_q;
	logic [7:0]     user_q [USER_BYTES];
	logic           pend_q;
	logic           alt_q;
	logic [1:0]     uidx_q;
	logic           udone_q;
	logic [RAMP_W-1:0] ramp_q;
	logic [22:0]    pn_long_q;
	logic [8:0]     pn_short_q;

	word_stream_if #(.W(DW + 1)) gen_s ();

	function automatic logic [45:0] pn_adv(
		input logic [31:0] s,
		input int          len,
		input int          tap
	);
		logic [31:0] st;
		logic [13:0] o;
		logic        fb;
		st = s;
		o = '0;
		fb = 1'b0;
		// The oldest bit leaves first and ends up in the top bit of the word.
		for (int i = 0; i < DW; i++) begin
			o = {o[12:0], st[0]};
			fb = st[0] ^ st[len-tap];
			st = st >> 1;
			st[len-1] = fb;
		end
		return {o, st};
	endfunction

	// Register decode.
	wire         soft_clr = (sr_state_q == SR_CLEAR);
	wire         wr_soft = reg_wr && (reg_addr == ADDR_SOFT_RESET);
	wire         wr_mode = reg_wr && (reg_addr == ADDR_TEST_MODE);
	wire         wr_trans = reg_wr && (reg_addr == ADDR_TRANSPORT);
	wire         wr_link = reg_wr && (reg_addr == ADDR_LINK_TEST);
	wire         wr_user = reg_wr && (reg_addr >= ADDR_USER_FIRST)
		&& (reg_addr <= ADDR_USER_LAST);
	wire [AW-1:0] user_off = reg_addr - ADDR_USER_FIRST;
	wire [2:0]   user_widx = user_off[2:0];
	wire         soft_cmd = wr_soft && ((reg_wdata & SOFT_RESET_MASK) != 8'h00);
	wire [3:0]   mode_q = test_mode_q[MODE_LSB +: 4];
	wire [3:0]   new_mode = reg_wdata[MODE_LSB +: 4];
	wire         mode_chg = wr_mode && (new_mode != mode_q);
	wire         user_single = test_mode_q[USER_SINGLE_BIT];
	wire         rd_user = (reg_addr >= ADDR_USER_FIRST)
		&& (reg_addr <= ADDR_USER_LAST);
	wire [7:0]   soft_rd = {soft_clr, pend_q, 5'h00, soft_clr};
	wire [7:0]   rd_word =
		(reg_addr == ADDR_SOFT_RESET) ? soft_rd :
		(reg_addr == ADDR_TEST_MODE) ? test_mode_q :
		rd_user ? user_q[user_widx] :
		(reg_addr == ADDR_TRANSPORT) ? transport_q :
		(reg_addr == ADDR_LINK_TEST) ? link_test_q : 8'h00;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sr_state_q <= SR_IDLE;
		end else begin
			case (sr_state_q)
				SR_IDLE: sr_state_q <= soft_cmd ? SR_CLEAR : SR_IDLE;
				SR_CLEAR: sr_state_q <= SR_IDLE;
				default: sr_state_q <= SR_IDLE;
			endcase
		end
	end

	// configuration registers, cleared again by the soft reset.
	always_ff @(posedge clk) begin
		if (!rst_n || soft_clr) begin
			test_mode_q <= TEST_MODE_RST;
			transport_q <= TRANSPORT_RST;
			link_test_q <= LINK_TEST_RST;
		end else begin
			if (wr_mode) begin
				test_mode_q <= reg_wdata;
			end
			if (wr_trans) begin
				transport_q <= reg_wdata;
			end
			if (wr_link) begin
				link_test_q <= reg_wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || soft_clr) begin
			for (int i = 0; i < USER_BYTES; i++) begin
				user_q[i] <= USER_RST;
			end
		end else if (wr_user) begin
			user_q[user_widx] <= reg_wdata;
		end
	end

	// leaving link tests without a soft reset is flagged.
	always_ff @(posedge clk) begin
		if (!rst_n || soft_clr) begin
			pend_q <= 1'b0;
		end else if (wr_link && reg_wdata == 8'h00 && link_test_q != 8'h00) begin
			pend_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? rd_word : 8'h00;
			reg_rvalid <= reg_rd;
		end
	end

	// Pattern selection.
	wire         fire = gen_s.ready;
	wire [45:0]  long_adv = pn_adv({9'h000, pn_long_q}, PN_LONG_LEN,
		PN_LONG_TAP);
	wire [45:0]  short_adv = pn_adv({23'h000000, pn_short_q}, PN_SHORT_LEN,
		PN_SHORT_TAP);
	wire [2:0]   ulo = {uidx_q, 1'b0};
	wire [2:0]   uhi = {uidx_q, 1'b1};
	wire [15:0]  user_word = {user_q[uhi], user_q[ulo]};
	// user words drop their two low bits.
	wire [DW-1:0] user_pat = udone_q ? PAT_ZEROS : user_word[15:USER_LSB];
	wire [DW-1:0] ramp_pat = {2'b00, ramp_q};
	wire [DW-1:0] fixed_pat =
		(mode_q == MODE_MIDSCALE) ? PAT_MIDSCALE :
		(mode_q == MODE_POS_FULL) ? PAT_POS_FULL :
		(mode_q == MODE_NEG_FULL) ? PAT_NEG_FULL :
		(mode_q == MODE_CHECKER) ? (alt_q ? PAT_CHECK_B : PAT_CHECK_A) :
		(mode_q == MODE_TOGGLE) ? (alt_q ? PAT_ZEROS : PAT_ONES) :
		PAT_ZEROS;
	wire         is_pn = (mode_q == MODE_PN_LONG) || (mode_q == MODE_PN_SHORT);
	wire         bypass = is_pn || (mode_q == MODE_USER);
	// any nonzero mode disconnects the converter result.
	wire [DW-1:0] gen_word =
		(mode_q == MODE_NORMAL) ? adc_data :
		(mode_q == MODE_PN_LONG) ? long_adv[45:32] :
		(mode_q == MODE_PN_SHORT) ? short_adv[45:32] :
		(mode_q == MODE_USER) ? user_pat :
		(mode_q == MODE_RAMP) ? ramp_pat : fixed_pat;
	wire         restart = mode_chg || soft_clr;

	// generator state moves only on clock edges that hand off a word.
	always_ff @(posedge clk) begin
		if (!rst_n || restart) begin
			alt_q <= 1'b0;
			ramp_q <= '0;
			uidx_q <= 2'b00;
			udone_q <= 1'b0;
		end else if (fire) begin
			alt_q <= !alt_q;
			ramp_q <= ramp_q + 12'h001;
			uidx_q <= uidx_q + 2'b01;
			// single mode stops after the fourth word.
			if (mode_q == MODE_USER && user_single && uidx_q == 2'b11) begin
				udone_q <= 1'b1;
			end
		end
	end

	// long sequence with its own reseed bit.
	always_ff @(posedge clk) begin
		if (!rst_n || restart || test_mode_q[PN_LONG_RST_BIT]) begin
			pn_long_q <= PN_LONG_SEED;
		end else if (fire && mode_q == MODE_PN_LONG) begin
			pn_long_q <= long_adv[22:0];
		end
	end

	// short sequence with its own reseed bit.
	always_ff @(posedge clk) begin
		if (!rst_n || restart || test_mode_q[PN_SHORT_RST_BIT]) begin
			pn_short_q <= PN_SHORT_SEED;
		end else if (fire && mode_q == MODE_PN_SHORT) begin
			pn_short_q <= short_adv[8:0];
		end
	end

	// The converter cannot be stalled, so a sample met by a full buffer is lost.
	assign gen_s.valid = 1'b1;
	assign gen_s.data = {bypass, gen_word};
	// a mode change flushes words still queued for the formatter.
	assign gen_s.flush = restart;

	word_skid_buffer #(.W(DW + 1)) out_buf (
		.clk     (clk),
		.rst_n   (rst_n),
		.up      (gen_s),
		.o_valid (out_valid),
		.o_ready (out_ready),
		.o_data  ({out_fmt_bypass, out_data})
	);

	// link controls leave as registered levels.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			test_active <= 1'b0;
			transport_test_en <= 1'b0;
			link_pattern_sel <= 4'h0;
			link_inject_sel <= 2'b00;
			link_exit_pending <= 1'b0;
		end else begin
			test_active <= (mode_q != MODE_NORMAL);
			transport_test_en <= transport_q[TRANSPORT_EN_BIT];
			link_pattern_sel <= link_test_q[LINK_SEL_LSB +: 4];
			link_inject_sel <= link_test_q[LINK_INJ_LSB +: 2];
			link_exit_pending <= pend_q;
		end
	end

	fixed_codes_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_q == MODE_POS_FULL |-> gen_word == PAT_POS_FULL) and
		(mode_q == MODE_NEG_FULL |-> gen_word == PAT_NEG_FULL) and
		(mode_q == MODE_MIDSCALE |-> gen_word == PAT_MIDSCALE))
		else $error("fixed code mismatch");

	path_select_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_q == MODE_NORMAL |-> gen_word == adc_data && !bypass) and
		(mode_q == MODE_RAMP |-> !bypass))
		else $error("wrong source or formatting flag");

	checker_alt_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_chg && new_mode == MODE_CHECKER && !soft_clr |=>
			gen_word == PAT_CHECK_A) and
		(fire && mode_q == MODE_CHECKER && gen_word == PAT_CHECK_A
			&& !restart |=> gen_word == PAT_CHECK_B))
		else $error("checkerboard order broken");

	pn_reseed_a: assert property (@(posedge clk) disable iff (!rst_n)
		(test_mode_q[PN_LONG_RST_BIT] |=> pn_long_q == PN_LONG_SEED) and
		(test_mode_q[PN_SHORT_RST_BIT] |=> pn_short_q == PN_SHORT_SEED))
		else $error("generators not reseeded");

	toggle_first_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_chg && new_mode == MODE_TOGGLE && !soft_clr |=>
			gen_word == PAT_ONES) and
		(fire && mode_q == MODE_TOGGLE && gen_word == PAT_ONES
			&& !restart |=> gen_word == PAT_ZEROS))
		else $error("word toggle order broken");

	user_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
		fire && mode_q == MODE_USER && !user_single && uidx_q == 2'b11
			&& !restart |=> uidx_q == 2'b00 && !udone_q)
		else $error("repeat mode did not cycle");

	user_single_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == MODE_USER && udone_q |-> gen_word == PAT_ZEROS)
		else $error("single mode not zero after four words");

	ramp_step_a: assert property (@(posedge clk) disable iff (!rst_n)
		fire && mode_q == MODE_RAMP && !restart |=>
			gen_word[RAMP_W-1:0] == $past(gen_word[RAMP_W-1:0]) + 12'h001)
		else $error("ramp did not step by one");

	soft_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		soft_cmd && sr_state_q == SR_IDLE |=> soft_clr ##1
			(!soft_clr && test_mode_q == TEST_MODE_RST))
		else $error("soft reset did not self clear");

	link_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_link && !soft_clr |-> ##2 link_pattern_sel == $past(reg_wdata[3:0], 2)
			&& link_inject_sel == $past(reg_wdata[5:4], 2))
		else $error("link selection not applied");
endmodule

// ### core/tpg_pkg.sv
// Constants, field layout and state types of the converter test pattern generator.
// Notes on behaviour
// - Mode nibble selects pattern; 0 is normal, 1-3 give midscale and full scales.
// - Any test mode replaces converter samples; some patterns skip formatting.
// - Checkerboard mode alternates 0x0AAA and 0x0555, starting with 0x0AAA.
// - Long pseudo-random mode uses x^23 + x^18 + 1 with seed 0x3AFF.
// - Short pseudo-random mode uses x^9 + x^5 + 1 with seed 0x0092.
// - Word toggle mode alternates 0x0FFF and 0x0000, starting with 0x0FFF.
// - Repeat user mode cycles user words one to four, bits 15 to 2.
// - Single user mode sends user words one to four once, then zeros.
// - Ramp mode counts up by one per sample, wrapping at twelve bits.
// - Setting bit 4 of the mode register reseeds the long generator, bit 5 the short one.
// - Patterns ignore the analog input and advance only on the running clock.
// - Writing 0x81 to the reset register starts a self-clearing soft reset.
// - Bit 5 of the transport register enables the transport sample test.
// - Link test pattern and injection point come from the link test register.
package tpg_pkg;
	localparam int AW = 12;
	localparam int DW = 14;
	localparam int RAMP_W = 12;
	localparam int USER_BYTES = 8;
	localparam logic [AW-1:0] ADDR_SOFT_RESET = 12'h000;
	localparam logic [AW-1:0] ADDR_TEST_MODE = 12'h550;
	localparam logic [AW-1:0] ADDR_USER_FIRST = 12'h551;
	localparam logic [AW-1:0] ADDR_USER_LAST = 12'h558;
	localparam logic [AW-1:0] ADDR_TRANSPORT = 12'h571;
	localparam logic [AW-1:0] ADDR_LINK_TEST = 12'h573;
	localparam logic [7:0] SOFT_RESET_MASK = 8'h81;
	localparam int SOFT_PEND_BIT = 6;
	localparam int MODE_LSB = 0;
	localparam int PN_LONG_RST_BIT = 4;
	localparam int PN_SHORT_RST_BIT = 5;
	localparam int USER_SINGLE_BIT = 7;
	localparam int TRANSPORT_EN_BIT = 5;
	localparam int LINK_SEL_LSB = 0;
	localparam int LINK_INJ_LSB = 4;
	localparam int USER_LSB = 2;
	localparam logic [7:0] TEST_MODE_RST = 8'h00;
	localparam logic [7:0] TRANSPORT_RST = 8'h00;
	localparam logic [7:0] LINK_TEST_RST = 8'h00;
	localparam logic [7:0] USER_RST = 8'h00;
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_MIDSCALE = 4'h1;
	localparam logic [3:0] MODE_POS_FULL = 4'h2;
	localparam logic [3:0] MODE_NEG_FULL = 4'h3;
	localparam logic [3:0] MODE_CHECKER = 4'h4;
	localparam logic [3:0] MODE_PN_LONG = 4'h5;
	localparam logic [3:0] MODE_PN_SHORT = 4'h6;
	localparam logic [3:0] MODE_TOGGLE = 4'h7;
	localparam logic [3:0] MODE_USER = 4'h8;
	localparam logic [3:0] MODE_RAMP = 4'hf;
	localparam logic [DW-1:0] PAT_MIDSCALE = 14'h0000;
	localparam logic [DW-1:0] PAT_POS_FULL = 14'h07ff;
	localparam logic [DW-1:0] PAT_NEG_FULL = 14'h0800;
	localparam logic [DW-1:0] PAT_CHECK_A = 14'h0aaa;
	localparam logic [DW-1:0] PAT_CHECK_B = 14'h0555;
	localparam logic [DW-1:0] PAT_ONES = 14'h0fff;
	localparam logic [DW-1:0] PAT_ZEROS = 14'h0000;
	localparam int PN_LONG_LEN = 23;
	localparam int PN_LONG_TAP = 18;
	localparam logic [22:0] PN_LONG_SEED = 23'h003aff;
	localparam int PN_SHORT_LEN = 9;
	localparam int PN_SHORT_TAP = 5;
	localparam logic [8:0] PN_SHORT_SEED = 9'h092;
	typedef enum logic [1:0] {
		SR_IDLE  = 2'b01,
		SR_CLEAR = 2'b10
	} soft_state_type;
endpackage

// ### core/word_skid_buffer.sv
// Two-entry skid buffer whose head entry drives the outputs directly.
`timescale 1ns/100ps
module word_skid_buffer #(
	parameter int W = 15
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	word_stream_if.snk        up,
	output logic              o_valid,
	input  wire logic         o_ready,
	output logic [W-1:0]      o_data
);
	logic         skid_v_q;
	logic [W-1:0] skid_q;
	logic         take;
	logic         head_free;

	// The second entry absorbs the word already in flight when ready drops.
	assign up.ready = !skid_v_q;
	assign take = up.valid && up.ready && !up.flush;
	assign head_free = !o_valid || o_ready;

	always_ff @(posedge clk) begin
		if (!rst_n || up.flush) begin
			o_valid <= 1'b0;
			skid_v_q <= 1'b0;
		end else if (head_free) begin
			o_valid <= skid_v_q || take;
			skid_v_q <= 1'b0;
		end else if (take) begin
			skid_v_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			o_data <= '0;
			skid_q <= '0;
		end else if (head_free) begin
			o_data <= skid_v_q ? skid_q : up.data;
		end else if (take) begin
			skid_q <= up.data;
		end
	end

	stall_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		o_valid && !o_ready && !up.flush |=> o_valid && $stable(o_data))
		else $error("buffered word changed while stalled");
endmodule

// ### core/word_stream_if.sv
// Valid/ready word stream between the generator and its output buffer.
`timescale 1ns/100ps
interface word_stream_if #(parameter int W = 15);
	logic         valid;
	logic         ready;
	logic         flush;
	logic [W-1:0] data;
	modport src (output valid, output data, output flush, input ready);
	modport snk (input valid, input data, input flush, output ready);
endinterface

// ### tb/fmt_sink_model.sv
// Behavioural formatting stage that accepts words promptly or slowly.
`timescale 1ns/100ps
module fmt_sink_model (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   stall,
	input  wire logic                   slow,
	input  wire logic                   out_valid,
	input  wire logic [tpg_pkg::DW-1:0] out_data,
	input  wire logic                   out_fmt_bypass,
	output logic                        out_ready
);
	import tpg_pkg::*;
	logic [1:0]  cnt_q;
	logic [DW:0] got[$];
	always @(posedge clk) begin
		cnt_q <= rst_n ? cnt_q + 2'h1 : 2'h0;
		out_ready <= rst_n && !stall && (!slow || cnt_q == 2'h0);
		if (rst_n && out_valid && out_ready) begin
			got.push_back({out_fmt_bypass, out_data});
		end
	end
endmodule

// ### tb/tb.sv
// Self-checking bench for the converter test pattern generator.
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	n_fail++; $display("unexpected at %0t got %h expected %h", \
	$time, (a), (b)); end end
module tb;
	import tpg_pkg::*;
	logic          clk, rst_n, reg_wr, reg_rd, reg_rvalid;
	logic [AW-1:0] reg_addr;
	logic [7:0]    reg_wdata, reg_rdata;
	logic [DW-1:0] adc_data, adc_hold, out_data;
	logic          out_valid, out_ready, out_fmt_bypass, test_active;
	logic          transport_test_en, link_exit_pending;
	logic [3:0]    link_pattern_sel;
	logic [1:0]    link_inject_sel;
	logic          stall, slow, adc_rand;
	logic [31:0]   seed_q;
	logic [7:0]    ub[8];
	logic [DW-1:0] uw[4];
	logic [DW-1:0] pl[5], ps[5];
	logic [7:0]    ml[11];
	int            n_fail = 0;
	int            samples_checked = 0;
	int            cyc = 0;
	adc_test_pattern_generator adc_test_pattern_generator_i (
		.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.adc_data(adc_data), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data),
		.out_fmt_bypass(out_fmt_bypass), .test_active(test_active),
		.transport_test_en(transport_test_en),
		.link_pattern_sel(link_pattern_sel),
		.link_inject_sel(link_inject_sel),
		.link_exit_pending(link_exit_pending));
	fmt_sink_model fmt_sink_model_i (
		.clk(clk), .rst_n(rst_n), .stall(stall), .slow(slow),
		.out_valid(out_valid), .out_data(out_data),
		.out_fmt_bypass(out_fmt_bypass), .out_ready(out_ready));
	always #2 clk = !clk;
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [DW-1:0] pn(inout int s, input int len,
			input int tap);
		int            fb;
		logic [DW-1:0] w;
		w = '0;
		for (int k = 0; k < DW; k++) begin
			w = {w[DW-2:0], s[0]};
			fb = (s ^ (s >> (len - tap))) & 1;
			s = (s >> 1) | (fb << (len - 1));
		end
		return w;
	endfunction
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [AW-1:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rvalid, 1'b1)
		`CHK(reg_rdata, e)
	endtask
	// Words already buffered before a reseed are skipped, hence sk.
	task automatic run(input logic [7:0] m, input int n,
			input logic [7:0] hv);
		int            sl, ss, sk;
		logic [DW-1:0] e;
		logic          b;
		logic [DW:0]   g;
		sl = 'h3aff;
		ss = 'h092;
		sk = (hv != 0) ? 2 : 0;
		slow <= m[0];
		wr(ADDR_TEST_MODE, m);
		if (hv != 0) begin
			repeat (4) @(posedge clk);
			wr(ADDR_TEST_MODE, hv);
			wr(ADDR_TEST_MODE, m);
		end
		repeat (4) @(posedge clk);
		`CHK(test_active, m[3:0] != 4'h0)
		fmt_sink_model_i.got.delete();
		stall <= 1'b0;
		for (int t = 0; t < 20000 && fmt_sink_model_i.got.size() < n + sk;
				t++) @(posedge clk);
		stall <= 1'b1;
		`CHK(fmt_sink_model_i.got.size() >= n + sk, 1'b1)
		for (int i = 0; i < n && i + sk < fmt_sink_model_i.got.size();
				i++) begin
			b = 1'b0;
			g = fmt_sink_model_i.got[i + sk];
			case (m[3:0])
				4'h0: e = adc_hold;
				4'h1: e = PAT_MIDSCALE;
				4'h2: e = PAT_POS_FULL;
				4'h3: e = PAT_NEG_FULL;
				4'h4: e = (i % 2) ? PAT_CHECK_B : PAT_CHECK_A;
				4'h7: e = (i % 2) ? PAT_ZEROS : PAT_ONES;
				4'h5: {b, e} = {1'b1, pn(sl, 23, 18)};
				4'h6: {b, e} = {1'b1, pn(ss, 9, 5)};
				4'h8: {b, e} = {1'b1, (m[7] && i > 3) ? 14'h0000 : uw[i % 4]};
				4'hf: e = DW'(i % 4096);
				default: e = 14'h0000;
			endcase
			if (m[3:0] == 4'h5 && i < 5) `CHK(g[DW-1:0], pl[i])
			if (m[3:0] == 4'h6 && i < 5) `CHK(g[DW-1:0], ps[i])
			`CHK(g, {b, e})
		end
	endtask
	always @(posedge clk) begin
		seed_q <= nxt(seed_q);
		adc_data <= adc_rand ? seed_q[DW-1:0] : adc_hold;
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		clk = 0; rst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = '0;
		reg_wdata = '0; stall = 1; slow = 0; adc_rand = 1;
		adc_hold = 14'h2b3c; adc_data = '0; seed_q = 32'he720;
		ml = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h09, 8'h05, 8'h06,
			8'h08, 8'h0f, 8'h88};
		pl = '{14'h3fd7, 14'h0002, 14'h26e0, 14'h0a3d, 14'h1ca6};
		ps = '{14'h125b, 14'h3c9a, 14'h2660, 14'h0c65, 14'h0697};
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADDR_TEST_MODE, 8'h00);
		rd(ADDR_LINK_TEST, 8'h00);
		wr(12'h400, 8'h5a);
		rd(12'h400, 8'h00);
		for (int k = 0; k < 8; k++) begin
			ub[k] = seed_q[7:0];
			wr(ADDR_USER_FIRST + AW'(k), ub[k]);
		end
		for (int k = 0; k < 4; k++) uw[k] = {ub[2*k+1], ub[2*k][7:2]};
		rd(ADDR_USER_LAST, ub[7]);
		foreach (ml[k]) run(ml[k], ml[k] == 8'h0f ? 4100 : 12, 8'h00);
		run(8'h05, 8, 8'h15);
		run(8'h06, 8, 8'h26);
		adc_rand <= 1'b0;
		run(8'h00, 6, 8'h00);
		wr(ADDR_TRANSPORT, 8'h20);
		repeat (2) @(posedge clk);
		#1 `CHK(transport_test_en, 1'b1)
		wr(ADDR_LINK_TEST, 8'h23);
		repeat (2) @(posedge clk);
		#1 `CHK({link_inject_sel, link_pattern_sel}, 6'h23)
		wr(ADDR_LINK_TEST, 8'h00);
		repeat (3) @(posedge clk);
		#1 `CHK(link_exit_pending, 1'b1)
		rd(ADDR_SOFT_RESET, 8'h40);
		wr(ADDR_SOFT_RESET, SOFT_RESET_MASK);
		repeat (3) @(posedge clk);
		rd(ADDR_SOFT_RESET, 8'h00);
		`CHK(link_exit_pending, 1'b0)
		rd(ADDR_TRANSPORT, 8'h00);
		summarize();
	end
endmodule
